/* rtl/srw_pkg.sv */
package srw_pkg;
	// clock rate and time base
	localparam int unsigned CLK_PERIOD_PS   = 8000;
	localparam int unsigned TICK_PERIOD_NS  = 1000;
	localparam int unsigned TICK_CYCLES     = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned TICK_CNT_W      = 8;
	// glitch rejection on the manual reset input, least time rounds up
	localparam int unsigned BTN_GLITCH_NS   = 100;
	localparam int unsigned BTN_FILT_CYCLES =
		(BTN_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	// debounce settle time on the manual reset input
	localparam int unsigned BTN_DEBOUNCE_US = 1;
	localparam int unsigned BTN_DEB_TICKS   = BTN_DEBOUNCE_US * 1000 / TICK_PERIOD_NS;
	// supply dip rejection
	localparam int unsigned SUP_GLITCH_US   = 8;
	localparam int unsigned SUP_DIP_TICKS   = SUP_GLITCH_US * 1000 / TICK_PERIOD_NS;
	// documented periods in time-base ticks
	localparam int unsigned HOLD_MS         = 200;
	localparam int unsigned HOLD_TICKS      = HOLD_MS * 1000000 / TICK_PERIOD_NS;
	localparam int unsigned WD_MS           = 1600;
	localparam int unsigned WD_TICKS        = WD_MS * 1000 / (TICK_PERIOD_NS / 1000);
	localparam int unsigned PERIOD_W        = 32;
	localparam int unsigned FILT_W          = 8;
	// level caught by the internal pull-up default
	localparam logic        BTN_IDLE_LEVEL  = 1'b1;
endpackage

/* rtl/srw_filter.sv */
`timescale 1ns/1ps
// level filter: output follows input once it has been steady for the given count
module srw_filter #(
	parameter int unsigned FILT_W    = 8,
	parameter int unsigned SETTLE    = 4,
	parameter logic        RST_LEVEL = 1'b1
) (
	input  wire logic clk_sys_in, // system clock
	input  wire logic rst_n_in,   // synchronous reset
	input  wire logic step_in,    // count enable
	input  wire logic level_in,   // synchronised raw level
	output logic      level_out   // filtered level
);
	logic [FILT_W-1:0] cnt_r;

	// restart the count whenever input and output disagree anew
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_r     <= '0;
			level_out <= RST_LEVEL;
		end else if (level_in == level_out) begin
			cnt_r <= '0;
		end else if (step_in) begin
			if (cnt_r >= FILT_W'(SETTLE - 1)) begin
				level_out <= level_in;
				cnt_r     <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

/* rtl/srw_supervisor.sv */
`timescale 1ns/1ps
// Operation
// R1: reset on low supply, manual, or watchdog
// R2: hold reset full hold period after cause
// R3: manual low asserts; release starts hold
// R4: manual input defaults high when undriven
// R5: manual input debounced to one reset
// R6: manual pulses under 100 ns ignored
// R7: both strobe edges clear; 50 ns detected
// R8: watchdog expiry asserts reset then holds
// R9: host toggles strobe within every period
// R10: supply or manual reset clears watchdog
// R11: watchdog cleared while reset asserted
// R12: floating strobe disables watchdog expiry
// R13: host keeps strobe mostly low
// R14: brief supply dips cause no reset
// R15: host strobes across call and subroutine
// R16: reset output active low, driven always
// R17: manual low held at least 1 us
// R18: periods are tick-count parameters
// R19: async inputs synchronised before use
// R20: power-up starts in reset
module srw_supervisor
	import srw_pkg::*;
#(
	parameter int unsigned HOLD_PERIOD = srw_pkg::HOLD_TICKS, // R18
	parameter int unsigned WD_PERIOD   = srw_pkg::WD_TICKS,   // R18
	parameter int unsigned DIP_PERIOD  = srw_pkg::SUP_DIP_TICKS
) (
	input  wire logic clk_sys_in,          // 125 MHz clock
	input  wire logic rst_n_in,            // synchronous reset, low active
	input  wire logic supply_low_in,       // supply below threshold
	input  wire logic manual_reset_n_in,   // push-button, low active
	input  wire logic manual_reset_oe_in,  // high while something drives the button pin
	input  wire logic watchdog_strobe_in,  // host strobe
	input  wire logic watchdog_float_in,   // high while strobe pin floats
	output logic      host_reset_n_out,    // reset to host, low active
	output logic      watchdog_expired_out // pulse on watchdog timeout
);
	import srw_pkg::*;

	typedef enum logic [1:0] {SRW_ASSERT, SRW_HOLD, SRW_RUN} srw_state_e;

	////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [1:0] sup_sync_r;
	logic [1:0] btn_sync_r;
	logic [1:0] stb_sync_r;
	logic [1:0] flt_sync_r;
	logic       stb_prev_r;
	logic       btn_pin;

	// undriven button reads high via the pull-up
	assign btn_pin = manual_reset_oe_in ? manual_reset_n_in : BTN_IDLE_LEVEL; // R4

	// two stages on every pin before any logic looks at it
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sup_sync_r <= 2'h3;
			btn_sync_r <= 2'h3;
			stb_sync_r <= 2'h0;
			flt_sync_r <= 2'h0;
		end else begin
			sup_sync_r <= {sup_sync_r[0], supply_low_in};      // R19
			btn_sync_r <= {btn_sync_r[0], btn_pin};            // R19
			stb_sync_r <= {stb_sync_r[0], watchdog_strobe_in}; // R19
			flt_sync_r <= {flt_sync_r[0], watchdog_float_in};  // R19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// time base: one-cycle tick every microsecond
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic                  tick_r;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// manual reset: glitch filter at clock rate, then debounce on ticks
	logic btn_glitch_free;
	logic btn_clean;

	srw_filter #(
		.FILT_W    (FILT_W),
		.SETTLE    (BTN_FILT_CYCLES),
		.RST_LEVEL (1'b1)
	) u_btn_glitch (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.step_in    (1'b1),
		.level_in   (btn_sync_r[1]),
		.level_out  (btn_glitch_free)
	); // R6

	// press is taken at the next tick, within a microsecond; bounces collapse into one press
	srw_filter #(
		.FILT_W    (FILT_W),
		.SETTLE    (BTN_DEB_TICKS),
		.RST_LEVEL (1'b1)
	) u_btn_debounce (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.step_in    (tick_r),
		.level_in   (btn_glitch_free),
		.level_out  (btn_clean)
	); // R5

	////////////////////////////////////////////////////////////////////////
	// supply dip rejection: only a sustained low counts
	logic [PERIOD_W-1:0] dip_cnt_r;
	logic                sup_low_r;

	// rise back above threshold clears at once; the hold covers recovery
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			dip_cnt_r <= '0;
			sup_low_r <= 1'b1; // R20
		end else if (!sup_sync_r[1]) begin
			dip_cnt_r <= '0;
			sup_low_r <= 1'b0;
		end else if (tick_r) begin
			if (dip_cnt_r >= PERIOD_W'(DIP_PERIOD)) begin
				sup_low_r <= 1'b1; // R14
			end else begin
				dip_cnt_r <= dip_cnt_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog: any strobe edge restarts the count
	logic [PERIOD_W-1:0] wd_cnt_r;
	logic                wd_edge;
	logic                wd_fire;
	srw_state_e          state_r;

	assign wd_edge = stb_sync_r[1] ^ stb_prev_r;
	assign wd_fire = tick_r && (wd_cnt_r >= PERIOD_W'(WD_PERIOD - 1)) && !flt_sync_r[1];

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			stb_prev_r <= 1'b0;
		end else begin
			stb_prev_r <= stb_sync_r[1];
		end
	end

	// held at zero throughout reset and hold; a floating pin halts it too
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wd_cnt_r <= '0;
		end else if (state_r != SRW_RUN) begin
			wd_cnt_r <= '0; // R11 R10
		end else if (wd_edge || flt_sync_r[1]) begin
			wd_cnt_r <= '0; // R7 R12
		end else if (wd_fire) begin
			wd_cnt_r <= '0;
		end else if (tick_r) begin
			wd_cnt_r <= wd_cnt_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset sequencer
	logic [PERIOD_W-1:0] hold_cnt_r;
	logic                cause;

	assign cause = sup_low_r || !btn_clean; // R1 R3

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_r    <= SRW_ASSERT; // R20
			hold_cnt_r <= '0;
		end else begin
			unique case (state_r)
				SRW_ASSERT: begin
					hold_cnt_r <= '0;
					if (!cause) begin
						state_r <= SRW_HOLD; // R2
					end
				end
				SRW_HOLD: begin
					if (cause) begin
						state_r    <= SRW_ASSERT;
						hold_cnt_r <= '0;
					end else if (tick_r) begin
						if (hold_cnt_r >= PERIOD_W'(HOLD_PERIOD - 1)) begin
							state_r <= SRW_RUN; // R2
						end else begin
							hold_cnt_r <= hold_cnt_r + 1'b1;
						end
					end
				end
				SRW_RUN: begin
					hold_cnt_r <= '0;
					if (cause) begin
						state_r <= SRW_ASSERT; // R1
					end else if (wd_fire && !wd_edge) begin
						state_r <= SRW_HOLD; // R8
					end
				end
			endcase
		end
	end

	// registered push-pull output, low in every state but run
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			host_reset_n_out     <= 1'b0; // R16
			watchdog_expired_out <= 1'b0;
		end else begin
			host_reset_n_out     <= (state_r == SRW_RUN) && !cause; // R16
			watchdog_expired_out <= (state_r == SRW_RUN) && !cause && wd_fire && !wd_edge;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_reset_on_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		cause |=> !host_reset_n_out) else $error("reset not asserted on cause"); // R1
	a_hold_after_release: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_r == SRW_ASSERT && !cause) |=> ##1 !host_reset_n_out[*3])
		else $error("reset released before hold"); // R2
	a_manual_low_resets: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!btn_clean |-> ##2 !host_reset_n_out) else $error("manual low missed"); // R3
	a_wd_clear_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_r != SRW_RUN |=> wd_cnt_r == '0) else $error("watchdog ran in reset"); // R11
	a_wd_edge_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		wd_edge |=> wd_cnt_r == '0) else $error("edge did not clear watchdog"); // R7
	a_wd_float_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		flt_sync_r[1] |=> wd_cnt_r == '0) else $error("floating watchdog counted"); // R12
	a_wd_fire_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		watchdog_expired_out |-> ##1 (!host_reset_n_out && state_r == SRW_HOLD))
		else $error("expiry without reset hold"); // R8
	a_dip_needs_time: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(sup_low_r) |-> dip_cnt_r >= PERIOD_W'(DIP_PERIOD))
		else $error("short dip flagged"); // R14
endmodule

/* tb/srw_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// host model: brief high strobe pulse once per service interval
module srw_host_model #(
	parameter int unsigned SERVICE_CYCLES = 2500
) (
	input  wire logic clk_sys_in, // system clock
	input  wire logic service_in, // host code running correctly
	output logic      strobe_out  // watchdog strobe to the block
);
	int unsigned cnt_r;
	initial begin
		strobe_out = 1'b0;
		cnt_r = 0;
	end
	// an 8 cycle high pulse keeps the pin mostly low, saving input current
	always @(posedge clk_sys_in) begin
		cnt_r <= service_in ? (cnt_r + 1) % SERVICE_CYCLES : 0;
		strobe_out <= #1 service_in && (cnt_r < 8);
	end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import srw_pkg::*;
	localparam int HOLD = 20;
	localparam int WDP  = 50;
	localparam int TK   = 125;
	logic clk_sys_in, rst_n_in, sup_low, btn_n, btn_oe, strobe, fl, host_en;
	logic rst_out, exp_out;
	int   n_fail, n_checks, t;

	srw_supervisor #(.HOLD_PERIOD(HOLD), .WD_PERIOD(WDP), .DIP_PERIOD(2)) dut_u (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .supply_low_in(sup_low),
		.manual_reset_n_in(btn_n), .manual_reset_oe_in(btn_oe),
		.watchdog_strobe_in(strobe), .watchdog_float_in(fl),
		.host_reset_n_out(rst_out), .watchdog_expired_out(exp_out));
	srw_host_model host_u (.clk_sys_in(clk_sys_in), .service_in(host_en), .strobe_out(strobe));

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic seen, input logic exp_v);
		n_checks++;
		if (seen !== exp_v) begin
			n_fail++;
			$display("Error at %0t: saw %b, expected %b", $time, seen, exp_v);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// bounded wait for the reset output to reach a level; t holds cycles taken
	task automatic wait_rst(input logic lvl, input int lim);
		t = 0;
		while (rst_out !== lvl && t < lim) begin
			cyc(1);
			t++;
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_power;
		chk(rst_out, 1'b0);
		wait_rst(1'b1, (HOLD + 4) * TK);
		chk(rst_out, 1'b1);
		chk(t >= (HOLD - 1) * TK, 1'b1);
	endtask
	task automatic t_supply;
		sup_low = 1'b1;
		cyc(TK);
		sup_low = 1'b0;
		cyc(10 * TK);
		chk(rst_out, 1'b1);
		sup_low = 1'b1;
		wait_rst(1'b0, 12 * TK);
		chk(rst_out, 1'b0);
		cyc(30 * TK);
		chk(rst_out, 1'b0);
		sup_low = 1'b0;
		cyc((HOLD - 1) * TK);
		chk(rst_out, 1'b0);
		wait_rst(1'b1, 4 * TK);
		chk(rst_out, 1'b1);
	endtask
	task automatic t_button;
		btn_n = 1'b0;
		cyc(10);
		btn_n = 1'b1;
		cyc(5 * TK);
		chk(rst_out, 1'b1);
		btn_oe = 1'b0;
		btn_n = 1'b0;
		cyc(10 * TK);
		chk(rst_out, 1'b1);
		btn_oe = 1'b1;
		// contact bounce before the button settles low
		repeat (4) begin
			btn_n = 1'b0;
			cyc(5);
			btn_n = 1'b1;
			cyc(5);
		end
		btn_n = 1'b0;
		wait_rst(1'b0, 5 * TK);
		chk(rst_out, 1'b0);
		cyc(5 * TK);
		btn_n = 1'b1;
		cyc((HOLD - 1) * TK);
		chk(rst_out, 1'b0);
		wait_rst(1'b1, 4 * TK);
		chk(rst_out, 1'b1);
	endtask
	task automatic t_watchdog;
		cyc(120 * TK);
		chk(rst_out, 1'b1);
		@(negedge strobe);
		host_en = 1'b0;
		t = 0;
		while (exp_out !== 1'b1 && t < (WDP + 3) * TK) begin
			cyc(1);
			t++;
		end
		chk(t >= (WDP - 1) * TK && t < (WDP + 3) * TK, 1'b1);
		// reset output follows the registered expiry pulse by one cycle
		cyc(1);
		chk(exp_out, 1'b0);
		chk(rst_out, 1'b0);
		wait_rst(1'b1, (HOLD + 4) * TK);
		chk(rst_out, 1'b1);
		cyc((WDP - 3) * TK);
		chk(rst_out, 1'b1);
		host_en = 1'b1;
		cyc(20 * TK);
		chk(rst_out, 1'b1);
	endtask
	task automatic t_float;
		fl = 1'b1;
		host_en = 1'b0;
		cyc((WDP + 10) * TK);
		chk(rst_out, 1'b1);
		host_en = 1'b1;
		cyc(10);
		fl = 1'b0;
		cyc(5 * TK);
		chk(rst_out, 1'b1);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_n_in = 1'b0;
		sup_low = 1'b0;
		btn_n = 1'b1;
		btn_oe = 1'b1;
		fl = 1'b0;
		host_en = 1'b1;
		cyc(5);
		rst_n_in = 1'b1;
		cyc(1);
		t_power();
		t_supply();
		t_button();
		t_watchdog();
		t_float();
		stop_test();
	end
	// hang guard, well beyond the roughly 460 us the scenarios need
	initial begin
		#700000;
		n_fail++;
		stop_test();
	end
endmodule
